// ### core/ubrt_top.sv
// ubrt_top: per-user burst parameters, ranging corrections and gap-safe commit
// assumes transmitter status, ticks and mini-slot count arrive on aclk
//
// Function
// (RL1) Ranging offset held as 16-bit integer plus 8-bit fraction of 6.25us/64.
// (RL2) Negative ranging adjustment lowers the offset, delaying later bursts.
// (RL3) Headend derives ranging feedback at 1/16384 frame-tick resolution.
// (RL4) TDMA ranging corrections applied no coarser than one symbol.
// (RL5) TDMA burst timing within 0.25us plus half symbol of mini-slots.
// (RL6) S-CDMA ranging correction accurate to one hundredth of a chip.
// (RL7) Variable burst length grants of 1 to 255 mini-slots accepted.
// (RL8) Up to 64 equalizer taps of 16-bit real and imaginary parts.
// (RL9) Signed offset frequency of plus or minus 32 kHz in 1 Hz.
// (RL10) Power commands in 1 dB steps, range by mode and modulation.
// (RL11) TDMA profile switches need no gap except the listed parameters.
// (RL12) Power change up to 1 dB needs 96 symbols plus 5us.
// (RL13) Power change above 1 dB needs 96 symbols plus 10us.
// (RL14) Parameters change only inside a sufficient gap between bursts; here modulation and mode change at once on a CTRL write.
// (RL15) Symbol rate changes wait for the descriptor change gap.
// (RL16) Offset frequency and ranging changes need a 96-symbol gap.
// (RL17) Channel frequency change needs 96 symbols plus 100 ms.
// (RL18) Modulation type changes need only the guard time; here they take effect at once, even during a burst.
// (RL19) S-CDMA power, frequency, equalizer, ranging changes need one frame.
// (RL20) Other S-CDMA changes need no extra reconfiguration time.
// (RL21) S-CDMA bursts stay aligned with the other modems.
// (RL22) Each burst starts at the granted mini-slot.
// (RL23) Maximum burst length zero marks the length as variable.
// (RL24) New values wait in shadow storage until a valid gap.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module ubrt_top #(
	parameter int unsigned CHAN_CYCLES = ubrt_pkg::CHAN_CYC,
	parameter int unsigned TAPS = ubrt_pkg::EQ_TAPS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic burst_on,
	input wire logic sym_tick,
	input wire logic frame_tick,
	input wire logic [15:0] mini_slot_now,
	output logic tx_start,
	output logic [7:0] tx_len,
	output logic scdma_mode,
	output ubrt_pkg::ubrt_mod_type tx_modulation,
	output logic [5:0] tx_power,
	output logic signed [15:0] tx_freq_offset,
	output logic [23:0] tx_range,
	output logic [31:0] tx_chan_freq,
	output logic [2:0] tx_sym_rate,
	output logic [TAPS-1:0][31:0] tx_eq
);
	import ubrt_pkg::*;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic scdma;
		ubrt_mod_type modulation;
		logic [7:0] max_burst;
		logic [5:0] sh_power;
		logic signed [15:0] sh_freq;
		logic [23:0] sh_range;
		logic [31:0] sh_chan;
		logic [2:0] sh_rate;
		logic [5:0] eq_index;
		logic [TAPS-1:0][31:0] sh_eq;
		logic [5:0] pend;
		logic [2:0] err;
		logic grant_wait;
		logic [15:0] grant_slot;
		logic [7:0] grant_len;
		logic start;
		logic [7:0] len;
		logic [5:0] power;
		logic signed [15:0] freq;
		logic [23:0] range;
		logic [31:0] chan;
		logic [2:0] rate;
		logic [TAPS-1:0][31:0] eq;
	} ubrt_state_type;

	ubrt_state_type s_r;
	ubrt_state_type s_nxt;
	ubrt_gap_if gap ();

	ubrt_gap #(
		.CHAN_CYCLES(CHAN_CYCLES)
	) u_gap (
		.aclk(aclk),
		.aresetn(aresetn),
		.gi(gap.timer)
	);

	assign gap.burst_on = burst_on;
	assign gap.sym_tick = sym_tick;
	assign gap.frame_tick = frame_tick;

	function automatic logic [5:0] pwr_ceiling(input logic scdma, input ubrt_mod_type m);
		logic [5:0] c;
		c = PWR_MAX_32_64;
		if (scdma)
			c = PWR_MAX_SCDMA;
		else
		begin
			case (m)
				UBRT_QPSK: c = PWR_MAX_QPSK;
				UBRT_QAM8, UBRT_QAM16: c = PWR_MAX_8_16;
				default: c = PWR_MAX_32_64;
			endcase
		end
		return c;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	always_comb
	begin
		logic [31:0] wv;
		logic [5:0] diff;
		logic gap_pwr;
		logic gap_tight;
		logic gap_chan;
		logic idle;
		wv = '0;
		diff = '0;
		gap_pwr = 1'b0;
		gap_tight = 1'b0;
		gap_chan = 1'b0;
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		idle = !burst_on;
		// bus write: address and data may arrive in either order
		if (s_axi_awvalid && s_r.awready)
		begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready)
		begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.aw_have && s_r.w_have && !s_r.bvalid)
		begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = 2'h0;
			case (s_r.awaddr)
				OFS_CTRL:
				begin
					wv = merge({28'h0000000, s_r.modulation, s_r.scdma}, s_r.wdata, s_r.wstrb);
					s_nxt.scdma = wv[0];
					// modulation swaps at once on the CTRL write, with no wait for a gap or guard time [RL18] [RL11]
					s_nxt.modulation = ubrt_mod_type'(wv[3:1]);
				end
				OFS_MAX_BURST: s_nxt.max_burst = 8'(merge(32'(s_r.max_burst), s_r.wdata, s_r.wstrb));
				OFS_POWER:
				begin
					wv = merge(32'(s_r.sh_power), s_r.wdata, s_r.wstrb);
					// whole dB steps inside the mode and modulation window [RL10]
					if (wv[31:6] == '0 && wv[5:0] >= PWR_MIN && wv[5:0] <= pwr_ceiling(s_r.scdma, s_r.modulation))
					begin
						s_nxt.sh_power = wv[5:0];
						s_nxt.pend[0] = wv[5:0] != s_r.power;
					end
					else
						s_nxt.err[0] = 1'b1;
				end
				OFS_FREQ_OFS:
				begin
					wv = merge(32'(unsigned'(s_r.sh_freq)), s_r.wdata, s_r.wstrb);
					// full +-32 kHz in 1 Hz units is carried to the synthesiser [RL9]
					if ($signed(wv[15:0]) <= FREQ_LIMIT && $signed(wv[15:0]) >= -FREQ_LIMIT)
					begin
						s_nxt.sh_freq = $signed(wv[15:0]);
						s_nxt.pend[1] = 1'b1;
					end
					else
						s_nxt.err[1] = 1'b1;
				end
				OFS_RANGE_INT:
				begin
					wv = merge(32'(s_r.sh_range[23:8]), s_r.wdata, s_r.wstrb);
					s_nxt.sh_range[23:8] = wv[15:0]; // [RL1]
					s_nxt.pend[2] = 1'b1;
				end
				OFS_RANGE_FRAC:
				begin
					wv = merge(32'(s_r.sh_range[7:0]), s_r.wdata, s_r.wstrb);
					s_nxt.sh_range[7:0] = wv[7:0]; // [RL1]
					s_nxt.pend[2] = 1'b1;
				end
				OFS_RANGE_ADJ:
				begin
					// signed 16.8 step; negative lowers the offset so bursts go later [RL2]
					s_nxt.sh_range = s_r.sh_range + s_r.wdata[23:0];
					s_nxt.pend[2] = 1'b1;
				end
				OFS_GRANT:
				begin
					// zero maximum means each grant carries its own length [RL23] [RL7]
					if (s_r.max_burst != 8'h00)
					begin
						s_nxt.grant_len = s_r.max_burst;
						s_nxt.grant_slot = s_r.wdata[31:16];
						s_nxt.grant_wait = 1'b1;
					end
					else if (s_r.wdata[7:0] != 8'h00)
					begin
						s_nxt.grant_len = s_r.wdata[7:0];
						s_nxt.grant_slot = s_r.wdata[31:16];
						s_nxt.grant_wait = 1'b1;
					end
					else
						s_nxt.err[2] = 1'b1;
				end
				OFS_STATUS: s_nxt.err = s_r.err & ~s_r.wdata[2:0];
				OFS_CHAN_FREQ:
				begin
					s_nxt.sh_chan = merge(s_r.sh_chan, s_r.wdata, s_r.wstrb);
					s_nxt.pend[3] = 1'b1;
				end
				OFS_SYM_RATE:
				begin
					s_nxt.sh_rate = s_r.wdata[2:0];
					s_nxt.pend[4] = 1'b1;
				end
				OFS_EQ_INDEX: s_nxt.eq_index = s_r.wdata[5:0];
				OFS_EQ_DATA:
				begin
					// real part in the upper half, imaginary in the lower [RL8]
					s_nxt.sh_eq[s_r.eq_index] = merge(s_r.sh_eq[s_r.eq_index], s_r.wdata, s_r.wstrb);
					s_nxt.eq_index = s_r.eq_index + 6'h01;
					s_nxt.pend[5] = 1'b1;
				end
				OFS_ACT_POWER, OFS_ACT_FREQ, OFS_ACT_RANGE: s_nxt.bresp = 2'h0;
				default: s_nxt.bresp = 2'h2;
			endcase
		end
		// a status write clears the error flags whose data bits are set
		if (s_r.aw_have && s_r.w_have && !s_r.bvalid && s_r.awaddr == OFS_STATUS)
			s_nxt.err = s_r.err & ~s_r.wdata[2:0];
		s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

		// bus read, answered one cycle after the address is taken
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		if (s_axi_arvalid && s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = 2'h0;
			s_nxt.rdata = '0;
			case (s_axi_araddr)
				OFS_CTRL: s_nxt.rdata = {28'h0000000, s_r.modulation, s_r.scdma};
				OFS_MAX_BURST: s_nxt.rdata = 32'(s_r.max_burst);
				OFS_POWER: s_nxt.rdata = 32'(s_r.sh_power);
				OFS_FREQ_OFS: s_nxt.rdata = 32'(s_r.sh_freq);
				OFS_RANGE_INT: s_nxt.rdata = 32'(s_r.sh_range[23:8]);
				OFS_RANGE_FRAC: s_nxt.rdata = 32'(s_r.sh_range[7:0]);
				OFS_GRANT: s_nxt.rdata = {s_r.grant_slot, 8'h00, s_r.grant_len};
				OFS_STATUS:
				begin
					s_nxt.rdata[ST_ERR_GRANT:ST_ERR_PWR] = s_r.err;
					s_nxt.rdata[ST_PEND_EQ:ST_PEND_PWR] = s_r.pend;
					s_nxt.rdata[ST_GRANT_WAIT] = s_r.grant_wait;
					s_nxt.rdata[ST_BURST_ON] = burst_on;
				end
				OFS_ACT_POWER: s_nxt.rdata = 32'(s_r.power);
				OFS_ACT_FREQ: s_nxt.rdata = 32'(s_r.freq);
				OFS_ACT_RANGE: s_nxt.rdata = 32'(s_r.range);
				OFS_CHAN_FREQ: s_nxt.rdata = s_r.sh_chan;
				OFS_SYM_RATE: s_nxt.rdata = 32'(s_r.sh_rate);
				OFS_EQ_INDEX: s_nxt.rdata = 32'(s_r.eq_index);
				OFS_EQ_DATA: s_nxt.rdata = s_r.sh_eq[s_r.eq_index];
				default: s_nxt.rresp = 2'h2;
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		// burst launch exactly on the granted slot [RL22]
		if (s_r.grant_wait && mini_slot_now == s_r.grant_slot)
		begin
			s_nxt.start = 1'b1;
			s_nxt.len = s_r.grant_len;
			s_nxt.grant_wait = 1'b0;
		end

		// shadow to active commit, only with the transmitter idle [RL24] [RL14]
		diff = s_r.sh_power > s_r.power ? s_r.sh_power - s_r.power : s_r.power - s_r.sh_power;
		if (s_r.scdma)
		begin
			// frame-aligned commits keep bursts in step with the other modems [RL19] [RL21]
			gap_pwr = gap.ok_frame;
			gap_tight = gap.ok_frame;
		end
		else
		begin
			gap_pwr = diff <= 6'h01 ? gap.ok_small : gap.ok_big; // [RL12] [RL13]
			gap_tight = gap.ok_min; // [RL16]
		end
		gap_chan = gap.ok_chan; // [RL17] [RL15]
		if (idle && s_r.pend[0] && gap_pwr && s_nxt.pend[0])
		begin
			s_nxt.power = s_r.sh_power;
			if (s_nxt.sh_power == s_r.sh_power)
				s_nxt.pend[0] = 1'b0;
		end
		if (idle && s_r.pend[1] && gap_tight)
		begin
			s_nxt.freq = s_r.sh_freq;
			if (s_nxt.sh_freq == s_r.sh_freq)
				s_nxt.pend[1] = 1'b0;
		end
		// full 1/16384-tick precision passed on, finer than a symbol or a hundredth chip [RL4] [RL5] [RL6]
		if (idle && s_r.pend[2] && gap_tight)
		begin
			s_nxt.range = s_r.sh_range;
			if (s_nxt.sh_range == s_r.sh_range)
				s_nxt.pend[2] = 1'b0;
		end
		if (idle && s_r.pend[3] && (s_r.scdma ? gap.ok_min : gap_chan))
		begin
			s_nxt.chan = s_r.sh_chan;
			if (s_nxt.sh_chan == s_r.sh_chan)
				s_nxt.pend[3] = 1'b0;
		end
		if (idle && s_r.pend[4] && (s_r.scdma ? gap.ok_min : gap_chan))
		begin
			s_nxt.rate = s_r.sh_rate;
			if (s_nxt.sh_rate == s_r.sh_rate)
				s_nxt.pend[4] = 1'b0;
		end
		// equalizer waits a frame in S-CDMA, free between bursts in TDMA [RL20] [RL11]
		if (idle && s_r.pend[5] && (!s_r.scdma || gap.ok_frame))
		begin
			s_nxt.eq = s_r.sh_eq;
			if (s_nxt.sh_eq == s_r.sh_eq)
				s_nxt.pend[5] = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
			s_r.max_burst <= RST_MAX_BURST;
			s_r.sh_power <= RST_POWER;
			s_r.power <= RST_POWER;
		end
		else
			s_r <= s_nxt;
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign tx_start = s_r.start;
	assign tx_len = s_r.len;
	assign scdma_mode = s_r.scdma;
	assign tx_modulation = s_r.modulation;
	assign tx_power = s_r.power;
	assign tx_freq_offset = s_r.freq;
	assign tx_range = s_r.range;
	assign tx_chan_freq = s_r.chan;
	assign tx_sym_rate = s_r.rate;
	assign tx_eq = s_r.eq;
endmodule

// ### core/ubrt_pkg.sv
// ubrt_pkg: constants shared by the burst reconfiguration timing block
// assumes a 50 MHz aclk and a 32-bit AXI4-Lite register bus
package ubrt_pkg;
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned GAP_SYMS = 96;
	localparam int unsigned PWR_SMALL_US = 5;
	localparam int unsigned PWR_BIG_US = 10;
	localparam int unsigned CHAN_MS = 100;
	localparam int unsigned PWR_SMALL_CYC = PWR_SMALL_US * CLK_MHZ;
	localparam int unsigned PWR_BIG_CYC = PWR_BIG_US * CLK_MHZ;
	localparam int unsigned CHAN_CYC = CHAN_MS * 1000 * CLK_MHZ;
	localparam int unsigned EQ_TAPS = 64;
	localparam int unsigned FRAMES_GAP = 2;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAX_BURST = 8'h04;
	localparam logic [7:0] OFS_POWER = 8'h08;
	localparam logic [7:0] OFS_FREQ_OFS = 8'h0c;
	localparam logic [7:0] OFS_RANGE_INT = 8'h10;
	localparam logic [7:0] OFS_RANGE_FRAC = 8'h14;
	localparam logic [7:0] OFS_RANGE_ADJ = 8'h18;
	localparam logic [7:0] OFS_GRANT = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_ACT_POWER = 8'h24;
	localparam logic [7:0] OFS_ACT_FREQ = 8'h28;
	localparam logic [7:0] OFS_ACT_RANGE = 8'h2c;
	localparam logic [7:0] OFS_CHAN_FREQ = 8'h30;
	localparam logic [7:0] OFS_SYM_RATE = 8'h34;
	localparam logic [7:0] OFS_EQ_INDEX = 8'h38;
	localparam logic [7:0] OFS_EQ_DATA = 8'h3c;
	// reset values
	localparam logic [5:0] RST_POWER = 6'h08;
	localparam logic [7:0] RST_MAX_BURST = 8'h00;
	// status bit positions
	localparam int unsigned ST_ERR_PWR = 0;
	localparam int unsigned ST_ERR_FREQ = 1;
	localparam int unsigned ST_ERR_GRANT = 2;
	localparam int unsigned ST_PEND_PWR = 8;
	localparam int unsigned ST_PEND_FREQ = 9;
	localparam int unsigned ST_PEND_RANGE = 10;
	localparam int unsigned ST_PEND_CHAN = 11;
	localparam int unsigned ST_PEND_RATE = 12;
	localparam int unsigned ST_PEND_EQ = 13;
	localparam int unsigned ST_GRANT_WAIT = 16;
	localparam int unsigned ST_BURST_ON = 17;
	// power limits in dBmV
	localparam logic [5:0] PWR_MIN = 6'h08;
	localparam logic [5:0] PWR_MAX_QPSK = 6'h3a;
	localparam logic [5:0] PWR_MAX_8_16 = 6'h37;
	localparam logic [5:0] PWR_MAX_32_64 = 6'h36;
	localparam logic [5:0] PWR_MAX_SCDMA = 6'h35;
	localparam logic signed [15:0] FREQ_LIMIT = 16'sh7d00;
	typedef enum logic [2:0] {
		UBRT_QPSK = 3'h0,
		UBRT_QAM8 = 3'h1,
		UBRT_QAM16 = 3'h2,
		UBRT_QAM32 = 3'h3,
		UBRT_QAM64 = 3'h4,
		UBRT_QAM128 = 3'h5
	} ubrt_mod_type;
endpackage

// ### core/ubrt_gap_if.sv
// ubrt_gap_if: burst activity in, inter-burst gap qualifiers out
// assumes all members are driven on aclk
`timescale 1ns/10ps
interface ubrt_gap_if;
	logic burst_on;
	logic sym_tick;
	logic frame_tick;
	logic ok_min;
	logic ok_small;
	logic ok_big;
	logic ok_chan;
	logic ok_frame;
	modport timer (input burst_on, sym_tick, frame_tick, output ok_min, ok_small, ok_big, ok_chan, ok_frame);
	modport user (output burst_on, sym_tick, frame_tick, input ok_min, ok_small, ok_big, ok_chan, ok_frame);
endinterface

// ### core/ubrt_gap.sv
// ubrt_gap: measures the idle time since the last burst ended
// assumes burst_on, sym_tick and frame_tick are synchronous to aclk
`timescale 1ns/10ps
module ubrt_gap #(
	parameter int unsigned CHAN_CYCLES = ubrt_pkg::CHAN_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	ubrt_gap_if.timer gi
);
	import ubrt_pkg::*;
	typedef struct packed {
		logic [6:0] syms;
		logic [22:0] cyc;
		logic [1:0] frames;
	} ubrt_gap_state_type;
	ubrt_gap_state_type s_r;
	ubrt_gap_state_type s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (gi.burst_on)
			s_nxt = '0;
		else
		begin
			// symbols first, then wall time on top of the 96 symbols
			if (s_r.syms < 7'(GAP_SYMS))
			begin
				if (gi.sym_tick)
					s_nxt.syms = s_r.syms + 7'h01;
			end
			else if (s_r.cyc != '1)
				s_nxt.cyc = s_r.cyc + 23'h000001;
			if (gi.frame_tick && s_r.frames < 2'(FRAMES_GAP))
				s_nxt.frames = s_r.frames + 2'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign gi.ok_min = !gi.burst_on && s_r.syms >= 7'(GAP_SYMS); // [RL16]
	assign gi.ok_small = gi.ok_min && s_r.cyc >= 23'(PWR_SMALL_CYC); // [RL12]
	assign gi.ok_big = gi.ok_min && s_r.cyc >= 23'(PWR_BIG_CYC); // [RL13]
	assign gi.ok_chan = gi.ok_min && s_r.cyc >= 23'(CHAN_CYCLES); // [RL17]
	// two boundaries seen means one whole frame lay in the gap
	assign gi.ok_frame = !gi.burst_on && s_r.frames >= 2'(FRAMES_GAP); // [RL19]
endmodule

// ### tb/ubrt_tx_model.sv
// ubrt_tx_model: transmitter and headend timing as seen by the block
// assumes the block's aclk, and that grants reach it as tx_start pulses
`timescale 1ns/10ps
module ubrt_tx_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tx_start,
	input wire logic [7:0] tx_len,
	output logic burst_on,
	output logic sym_tick,
	output logic frame_tick,
	output logic [15:0] mini_slot_now
);
	logic [11:0] div_r;
	logic [11:0] left_r;
	// short symbol and frame so that gaps fit a short run
	assign sym_tick = div_r[1:0] == 2'h3;
	assign frame_tick = div_r[5:0] == 6'h3f;
	assign burst_on = left_r != 12'h0;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_r <= 12'h0;
			left_r <= 12'h0;
			mini_slot_now <= 16'h0;
		end
		else
		begin
			div_r <= div_r + 12'h1;
			if (div_r[2:0] == 3'h7)
				mini_slot_now <= mini_slot_now + 16'h1;
			// bursts only on grants, so every gap is one the headend allowed
			if (tx_start)
				left_r <= {1'b0, tx_len, 3'h0};
			else if (burst_on)
				left_r <= left_r - 12'h1;
		end
	end
endmodule

// ### tb/ubrt_top_chk.sv
// ubrt_top_chk: gap and hold checks on the committed transmit settings
// assumes it is bound to ubrt_top and sees only its ports
`timescale 1ns/10ps
module ubrt_top_chk
	import ubrt_pkg::*;
#(
	parameter int unsigned CHAN_CYCLES = 300
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic burst_on,
	input wire logic sym_tick,
	input wire logic frame_tick,
	input wire logic tx_start,
	input wire logic [7:0] tx_len,
	input wire logic scdma_mode,
	input wire logic [5:0] tx_power,
	input wire logic signed [15:0] tx_freq_offset,
	input wire logic [23:0] tx_range,
	input wire logic [31:0] tx_chan_freq,
	input wire logic [2:0] tx_sym_rate
);
	logic [6:0] sym_r;
	logic [19:0] post_r;
	logic [1:0] frm_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// idle time since the last burst, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn || burst_on)
		begin
			sym_r <= 7'h0;
			post_r <= 20'h0;
			frm_r <= 2'h0;
		end
		else
		begin
			if (sym_tick && sym_r != 7'd96)
				sym_r <= sym_r + 7'h1;
			if (sym_r == 7'd96 && post_r != 20'hfffff)
				post_r <= post_r + 20'h1;
			if (frame_tick && frm_r != 2'h2)
				frm_r <= frm_r + 2'h1;
		end
	end
	// commit may land on the edge where burst_on rises, so look from the third
	a_power_quiet: assert property (burst_on [*3] |-> $stable(tx_power))
		else $error("power moved during a burst");
	a_freq_quiet: assert property (burst_on [*3] |-> $stable(tx_freq_offset) && $stable(tx_range))
		else $error("offset or range moved during a burst");
	a_chan_quiet: assert property (burst_on [*3] |-> $stable(tx_chan_freq) && $stable(tx_sym_rate))
		else $error("channel or rate moved during a burst");
	a_small_gap: assert property (!scdma_mode && $changed(tx_power) |-> sym_r == 7'd96 && post_r >= PWR_SMALL_CYC - 1)
		else $error("power committed before small gap");
	a_big_gap: assert property (!scdma_mode && $changed(tx_power) && (tx_power > $past(tx_power) + 1 ||
		$past(tx_power) > tx_power + 1) |-> post_r >= PWR_BIG_CYC - 1)
		else $error("large power step before big gap");
	a_range_gap: assert property (!scdma_mode && ($changed(tx_range) || $changed(tx_freq_offset)) |-> sym_r == 7'd96)
		else $error("offset or range committed before 96 symbols");
	a_chan_gap: assert property (!scdma_mode && ($changed(tx_chan_freq) || $changed(tx_sym_rate)) |->
		post_r >= CHAN_CYCLES - 1)
		else $error("channel committed before its gap");
	a_frame_gap: assert property (scdma_mode && ($changed(tx_power) || $changed(tx_range)) |-> frm_r == 2'h2)
		else $error("frame-mode commit before two frames");
	a_start_pulse: assert property (tx_start |-> tx_len != 8'h0 ##1 !tx_start)
		else $error("bad burst start");
	a_power_span: assert property (tx_power >= PWR_MIN && tx_power <= PWR_MAX_QPSK)
		else $error("active power out of range");
	c_start: cover property (tx_start);
	c_frame_commit: cover property (scdma_mode && $changed(tx_power));
	c_chan_commit: cover property ($changed(tx_chan_freq));
endmodule
bind ubrt_top ubrt_top_chk #(.CHAN_CYCLES(CHAN_CYCLES)) u_ubrt_top_chk (.aclk(aclk), .aresetn(aresetn),
	.burst_on(burst_on), .sym_tick(sym_tick), .frame_tick(frame_tick), .tx_start(tx_start), .tx_len(tx_len),
	.scdma_mode(scdma_mode), .tx_power(tx_power), .tx_freq_offset(tx_freq_offset), .tx_range(tx_range),
	.tx_chan_freq(tx_chan_freq), .tx_sym_rate(tx_sym_rate));

// ### tb/tb_top.sv
// tb_top: register scenarios for ubrt_top against a transmitter model
// assumes the checker binds itself from its own file
`timescale 1ns/10ps
module tb_top;
	import ubrt_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, tx_chan_freq, lfsr = 32'h90b5;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, burst_on, sym_tick, frame_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] mini_slot_now, g;
	logic tx_start, scdma_mode;
	logic [7:0] tx_len;
	ubrt_mod_type tx_modulation;
	logic [5:0] tx_power;
	logic signed [15:0] tx_freq_offset, f;
	logic [23:0] tx_range;
	logic [2:0] tx_sym_rate;
	logic [63:0][31:0] tx_eq;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	int err_total = 0, n_checks = 0, cyc = 0;
	ubrt_top #(.CHAN_CYCLES(300), .TAPS(64)) u_ubrt_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .burst_on(burst_on),
		.sym_tick(sym_tick), .frame_tick(frame_tick), .mini_slot_now(mini_slot_now), .tx_start(tx_start),
		.tx_len(tx_len), .scdma_mode(scdma_mode), .tx_modulation(tx_modulation), .tx_power(tx_power),
		.tx_freq_offset(tx_freq_offset), .tx_range(tx_range), .tx_chan_freq(tx_chan_freq),
		.tx_sym_rate(tx_sym_rate), .tx_eq(tx_eq));
	ubrt_tx_model u_ubrt_tx_model (.aclk(aclk), .aresetn(aresetn), .tx_start(tx_start), .tx_len(tx_len),
		.burst_on(burst_on), .sym_tick(sym_tick), .frame_tick(frame_tick), .mini_slot_now(mini_slot_now));
	initial forever #10 aclk = ~aclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic final_report;
		if (err_total == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (s_axi_awready && !aw)
			begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w)
			begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r = 2'h0);
		@(posedge aclk);
		rq.push_back({r, m, d & m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	// polls one active setting until it commits, then compares
	task automatic wait_tx(input int s, input logic [31:0] exp);
		logic [31:0] v;
		for (int k = 0; k < 4000; k++)
		begin
			@(posedge aclk);
			v = s == 0 ? {26'h0, tx_power} : s == 1 ? {16'h0, tx_freq_offset} : s == 2 ? {8'h0, tx_range} : tx_chan_freq;
			if (v === exp)
				break;
		end
		chk(v, exp);
	endtask
	always @(posedge aclk)
	begin
		logic [65:0] e;
		cyc++;
		if (s_axi_rvalid && s_axi_rready)
		begin
			e = rq.pop_front();
			chk(s_axi_rdata & e[63:32], e[31:0]);
			chk({30'h0, s_axi_rresp}, {30'h0, e[65:64]});
		end
		if (s_axi_bvalid && s_axi_bready)
			chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
		if (cyc > 40000)
		begin
			err_total++;
			$display("BAD %0t timeout", $time);
			final_report();
		end
	end
	initial
	begin
		logic [7:0] mx [6] = '{8'd58, 8'd55, 8'd55, 8'd54, 8'd54, 8'd54};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk({26'h0, tx_power}, 32'h8);
		rd(OFS_POWER, 32'h8, 32'h3f);
		rd(OFS_MAX_BURST, 32'h0, 32'hff);
		rd(8'h40, 32'h0, 32'h0, 2'h2);
		wr(8'h44, 32'h1, 2'h2);
		wr(OFS_GRANT, 32'h0005_0000);
		rd(OFS_STATUS, 32'h4, 32'h7);
		wr(OFS_STATUS, 32'h7);
		for (int m = 0; m < 6; m++)
		begin
			wr(OFS_CTRL, m << 1);
			wr(OFS_POWER, mx[m] + 8'h1);
			rd(OFS_STATUS, 32'h1, 32'h1);
			wr(OFS_STATUS, 32'h1);
			wr(OFS_POWER, mx[m]);
			rd(OFS_STATUS, 32'h0, 32'h1);
			chk({29'h0, tx_modulation}, m);
		end
		wait_tx(0, 32'd54);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_POWER, 32'd54);
		rd(OFS_STATUS, 32'h1, 32'h1);
		wr(OFS_STATUS, 32'h1);
		wr(OFS_CTRL, 32'h0);
		g = mini_slot_now + 16'h4;
		wr(OFS_GRANT, {g, 16'h00ff});
		while (!tx_start) @(posedge aclk);
		chk({24'h0, tx_len}, 32'hff);
		chk({31'h0, (mini_slot_now - g) <= 16'h1}, 32'h1);
		lfsr = lfsr_next(lfsr);
		f = 16'(int'(lfsr % 64001) - 32000);
		wr(OFS_POWER, 32'd53);
		wr(OFS_FREQ_OFS, {{16{f[15]}}, f});
		wr(OFS_RANGE_INT, 32'h0100);
		wr(OFS_RANGE_FRAC, 32'h80);
		chk({26'h0, tx_power}, 32'd54);
		rd(OFS_STATUS, 32'h0002_0100, 32'h0002_0100);
		wait_tx(0, 32'd53);
		wait_tx(1, {16'h0, f});
		wait_tx(2, 32'h01_0080);
		wr(OFS_FREQ_OFS, 32'd32001);
		rd(OFS_STATUS, 32'h2, 32'h2);
		wr(OFS_STATUS, 32'h2);
		wr(OFS_RANGE_ADJ, 32'h00ff_ffff);
		wait_tx(2, 32'h01_007f);
		wr(OFS_RANGE_ADJ, 32'h0000_0100);
		wait_tx(2, 32'h01_017f);
		wr(OFS_SYM_RATE, 32'h5);
		wr(OFS_CHAN_FREQ, 32'h1234_5678);
		wait_tx(3, 32'h1234_5678);
		chk({29'h0, tx_sym_rate}, 32'h5);
		wr(OFS_EQ_INDEX, 32'd62);
		wr(OFS_EQ_DATA, 32'ha5a5_5a5a);
		wr(OFS_EQ_DATA, 32'h0123_fedc);
		@(posedge aclk);
		chk(tx_eq[62], 32'ha5a5_5a5a);
		chk(tx_eq[63], 32'h0123_fedc);
		wr(OFS_CTRL, 32'h1);
		chk({31'h0, scdma_mode}, 32'h1);
		wr(OFS_GRANT, {mini_slot_now + 16'h4, 16'h0002});
		while (!tx_start) @(posedge aclk);
		wr(OFS_POWER, 32'd50);
		wait_tx(0, 32'd50);
		wr(OFS_ACT_POWER, 32'h0);
		rd(OFS_ACT_POWER, 32'd50, 32'h3f);
		final_report();
	end
endmodule
